// ---- rtl/rfc_defines.svh ----
`ifndef RFC_DEFINES_SVH
`define RFC_DEFINES_SVH
// timing
`define RFC_CLK_HZ 25000000
`define RFC_TICK_S 1
`define RFC_TICK_CYCLES (`RFC_CLK_HZ * `RFC_TICK_S)
`define RFC_SAVER_S 3600
// holdoff limits and reset values, seconds
`define RFC_HOLD_MIN 7'h02
`define RFC_HOLD_MAX 7'h63
`define RFC_BU_HOLD_RST 7'h05
`define RFC_RS_HOLD_RST 7'h05
// display geometry
`define RFC_DISP_LINES 2
`define RFC_DISP_COLS 24
// register byte offsets
`define RFC_OFF_CTRL 8'h00
`define RFC_OFF_HOLD 8'h04
`define RFC_OFF_STAT 8'h08
`define RFC_OFF_EVENT 8'h0c
`define RFC_OFF_DISP 8'h10
// ctrl fields
`define RFC_CTRL_AUTO 0
`define RFC_CTRL_RESTORE 1
`define RFC_CTRL_MASK_MOD 2
`define RFC_CTRL_MASK_DEMOD 3
`define RFC_CTRL_ACTIVE_LSB 8
`define RFC_CTRL_RST 32'h0000_0000
// hold fields
`define RFC_HOLD_BU_LSB 0
`define RFC_HOLD_RS_LSB 8
// disp fields
`define RFC_DISP_NUMERIC 0
`define RFC_DISP_LINE 1
`define RFC_DISP_COL_LSB 2
// axi responses
`define RFC_RESP_OKAY 2'h0
`define RFC_RESP_SLVERR 2'h2
`endif

// ---- rtl/rfc_pkg.sv ----
package rfc_pkg;
   typedef enum logic [2:0] {
      RFC_IDLE = 3'h1,
      RFC_BRIDGE = 3'h2,
      RFC_BACKUP = 3'h4
   } rfc_state_type;
endpackage : rfc_pkg

// ---- rtl/rfc_failover_ctrl.sv ----
// How it works
// - manual mode: no automatic switching at all
// - auto: first failing active unit gets backed up
// - backup holdoff 2..99 seconds, default five
// - fault held, spare clean, whole holdoff
// - bridge first, then complete backup
// - restore holdoff programmable 2..99 seconds
// - auto-restore after fault clear for holdoff
// - no auto-restore: failed unit stays offline
// - recovered unit retaken when another unit fails
// - no priority, first qualified served first
// - simultaneous qualification: lower position wins
// - global mod/demod masks block action, logging
// - masks apply to every traffic position
// - no IF switch: offline modulator IF off
// - sense external IF switch presence itself
// - IF switch present: offline modulator stays on
// - stored event indicator blinks in manual
// - display is two lines of 24 characters
// - flashing block cursor, underline on numeric edit
// - one idle hour starts scrolling screen saver
// - any key ends saver, prior screen returns
// - reset: manual mode, no units active
`include "rfc_defines.svh"
module rfc_failover_ctrl #(
   parameter int UNITS = 8,
   parameter int TICK_CYCLES = `RFC_TICK_CYCLES,
   parameter int SAVER_S = `RFC_SAVER_S
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // fault reports
   input wire logic [UNITS-1:0] traffic_mod_fault,
   input wire logic [UNITS-1:0] traffic_demod_fault,
   input wire logic spare_mod_fault,
   input wire logic spare_demod_fault,
   // external IF switch and keypad
   input wire logic if_switch_sense,
   input wire logic key_press,
   // switching outputs
   output logic [UNITS-1:0] traffic_unit_interface_online,
   output logic [UNITS-1:0] traffic_unit_interface_bridged,
   output logic [UNITS-1:0] traffic_tx_if_enable,
   output logic spare_unit_interface_online,
   output logic spare_tx_if_enable,
   // front panel
   output logic stored_event_led,
   output logic cursor_on,
   output logic cursor_underline,
   output logic cursor_line,
   output logic [4:0] cursor_col,
   output logic saver_active,
   output logic [4:0] saver_scroll
);
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [UNITS-1:0] NO_UNITS = '0;

   if (UNITS < 1 || UNITS > 8 || TICK_CYCLES < 1 || SAVER_S < 1 ||
      SAVER_S > 4095) begin : g_bad_param
      $error("rfc_failover_ctrl: unsupported parameter value");
   end

   // one second tick
   logic [TW-1:0] tick_cnt, next_tick_cnt;
   logic tick, next_tick;
   always_comb begin
      next_tick = 1'b0;
      next_tick_cnt = tick_cnt + TW'(1);
      if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
         next_tick_cnt = '0;
         next_tick = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick <= next_tick;
      end
   end

   // ---------------- configuration registers
   logic [31:0] ctrl, next_ctrl;
   logic [6:0] bu_hold, next_bu_hold, rs_hold, next_rs_hold;
   logic [UNITS-1:0] event_log, next_event_log;
   logic disp_numeric, next_disp_numeric;
   logic disp_line, next_disp_line;
   logic [4:0] disp_col, next_disp_col;
   logic auto_mode, auto_restore, mask_mod, mask_demod;
   logic [UNITS-1:0] active;
   assign auto_mode = ctrl[`RFC_CTRL_AUTO];
   assign auto_restore = ctrl[`RFC_CTRL_RESTORE];
   assign mask_mod = ctrl[`RFC_CTRL_MASK_MOD];
   assign mask_demod = ctrl[`RFC_CTRL_MASK_DEMOD];
   assign active = ctrl[`RFC_CTRL_ACTIVE_LSB +: UNITS];

   // ---------------- fault qualification
   logic [UNITS-1:0] fault_seen, qualify, ready;
   logic [6:0] hold_cnt [UNITS];
   logic [6:0] next_hold_cnt [UNITS];
   always_comb begin
      for (int i = 0; i < UNITS; i++) begin
         // masks are global, one bit covers every position
         fault_seen[i] = active[i] & ((traffic_mod_fault[i] & ~mask_mod) |
            (traffic_demod_fault[i] & ~mask_demod));
         // a fault the spare also shows cannot be cured by switching
         qualify[i] = active[i] &
            ((traffic_mod_fault[i] & ~mask_mod & ~spare_mod_fault) |
            (traffic_demod_fault[i] & ~mask_demod &
            ~spare_demod_fault));
         next_hold_cnt[i] = '0;
         if (qualify[i]) begin
            next_hold_cnt[i] = hold_cnt[i];
            if (tick && hold_cnt[i] != 7'h7f) begin
               next_hold_cnt[i] = hold_cnt[i] + 7'h01;
            end
         end
         ready[i] = qualify[i] && (hold_cnt[i] > bu_hold);
      end
   end
   always_ff @(posedge clk) begin
      for (int i = 0; i < UNITS; i++) begin
         if (!rst_n) begin
            hold_cnt[i] <= '0;
         end else begin
            hold_cnt[i] <= next_hold_cnt[i];
         end
      end
   end

   // ---------------- failover state machine
   rfc_pkg::rfc_state_type state, next_state;
   logic [2:0] served, next_served;
   logic [6:0] rs_cnt, next_rs_cnt;
   logic [2:0] pick;
   logic pick_ok, other_ready;
   always_comb begin
      pick = '0;
      pick_ok = 1'b0;
      other_ready = 1'b0;
      // counters run per unit, so the earliest qualified reaches first;
      // a tie in one cycle resolves to the lower position
      for (int i = UNITS - 1; i >= 0; i--) begin
         if (ready[i]) begin
            pick = 3'(i);
            pick_ok = 1'b1;
         end
         if (ready[i] && 3'(i) != served) begin
            other_ready = 1'b1;
         end
      end
   end
   always_comb begin
      next_state = state;
      next_served = served;
      next_rs_cnt = '0;
      if (fault_seen[served] == 1'b0 && state == rfc_pkg::RFC_BACKUP) begin
         next_rs_cnt = rs_cnt;
         if (tick && rs_cnt != 7'h7f) begin
            next_rs_cnt = rs_cnt + 7'h01;
         end
      end
      case (state)
         rfc_pkg::RFC_IDLE: begin
            // spare is free only here, so one unit at a time
            if (auto_mode && pick_ok) begin
               next_served = pick;
               next_state = rfc_pkg::RFC_BRIDGE;
            end
         end
         rfc_pkg::RFC_BRIDGE: begin
            if (auto_mode) begin
               next_state = rfc_pkg::RFC_BACKUP;
            end
         end
         rfc_pkg::RFC_BACKUP: begin
            if (!active[served]) begin
               next_state = rfc_pkg::RFC_IDLE;
            end else if (auto_mode) begin
               if (auto_restore && rs_cnt > rs_hold) begin
                  next_state = rfc_pkg::RFC_IDLE;
               end else if (!fault_seen[served] && other_ready) begin
                  next_state = rfc_pkg::RFC_IDLE;
               end
            end
         end
         default: begin
            next_state = rfc_pkg::RFC_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= rfc_pkg::RFC_IDLE;
         served <= '0;
         rs_cnt <= '0;
      end else begin
         state <= next_state;
         served <= next_served;
         rs_cnt <= next_rs_cnt;
      end
   end

   // ---------------- switching outputs
   logic if_switch_present, next_if_switch_present;
   logic [UNITS-1:0] next_online, next_bridged, next_tx_en;
   logic next_spare_online;
   always_comb begin
      next_if_switch_present = if_switch_sense;
      next_bridged = NO_UNITS;
      if (next_state != rfc_pkg::RFC_IDLE) begin
         next_bridged[next_served] = 1'b1;
      end
      next_spare_online = (next_state == rfc_pkg::RFC_BACKUP);
      next_online = active;
      if (next_spare_online) begin
         next_online[next_served] = 1'b0;
      end
      // with relays outside, isolation is theirs, so the IF stays up
      if (if_switch_present) begin
         next_tx_en = active;
      end else begin
         next_tx_en = next_online;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         if_switch_present <= 1'b0;
         traffic_unit_interface_online <= NO_UNITS;
         traffic_unit_interface_bridged <= NO_UNITS;
         traffic_tx_if_enable <= NO_UNITS;
         spare_unit_interface_online <= 1'b0;
         spare_tx_if_enable <= 1'b0;
      end else begin
         if_switch_present <= next_if_switch_present;
         traffic_unit_interface_online <= next_online;
         traffic_unit_interface_bridged <= next_bridged;
         traffic_tx_if_enable <= next_tx_en;
         spare_unit_interface_online <= next_spare_online;
         spare_tx_if_enable <= next_spare_online;
      end
   end

   // ---------------- front panel
   logic blink, next_blink;
   logic [11:0] idle_s, next_idle_s;
   logic next_saver_active, next_led, next_cursor_on;
   logic [4:0] next_scroll;
   always_comb begin
      next_blink = tick ? ~blink : blink;
      next_led = auto_mode ? |event_log : next_blink;
      next_cursor_on = next_blink;
      next_idle_s = idle_s;
      next_saver_active = saver_active;
      next_scroll = saver_scroll;
      if (key_press) begin
         next_idle_s = '0;
         next_saver_active = 1'b0;
         next_scroll = '0;
      end else if (tick) begin
         if (idle_s != 12'(SAVER_S)) begin
            next_idle_s = idle_s + 12'h001;
         end else begin
            next_saver_active = 1'b1;
         end
         if (saver_active) begin
            // message walks one column per second across the line
            next_scroll = (saver_scroll == 5'(`RFC_DISP_COLS - 1)) ?
               5'h00 : saver_scroll + 5'h01;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blink <= 1'b0;
         idle_s <= '0;
         saver_active <= 1'b0;
         saver_scroll <= '0;
         stored_event_led <= 1'b0;
         cursor_on <= 1'b0;
         cursor_underline <= 1'b0;
         cursor_line <= 1'b0;
         cursor_col <= '0;
      end else begin
         blink <= next_blink;
         idle_s <= next_idle_s;
         saver_active <= next_saver_active;
         saver_scroll <= next_scroll;
         stored_event_led <= next_led;
         cursor_on <= next_cursor_on;
         cursor_underline <= next_disp_numeric;
         cursor_line <= next_disp_line;
         cursor_col <= next_disp_col;
      end
   end

   // ---------------- axi4-lite slave and register writes
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data, bmask, wr_val;
   logic [3:0] w_strb, next_w_strb;
   logic next_bvalid, next_awready, next_wready, do_write;
   logic [1:0] next_bresp, next_rresp;
   logic next_arready, next_rvalid;
   logic [31:0] next_rdata, stat_word;
   logic [6:0] new_bu, new_rs;
   logic [4:0] new_col;
   always_comb begin
      stat_word = '0;
      stat_word[0] = if_switch_present;
      stat_word[1] = saver_active;
      stat_word[4:2] = served;
      stat_word[7:5] = state;
      stat_word[8 +: UNITS] = traffic_unit_interface_online;
      stat_word[16 +: UNITS] = traffic_unit_interface_bridged;
      stat_word[24] = spare_unit_interface_online;
   end
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_write = aw_held && w_held && !s_axi_bvalid;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      for (int b = 0; b < 4; b++) begin
         bmask[b*8 +: 8] = {8{w_strb[b]}};
      end
      next_ctrl = ctrl;
      next_bu_hold = bu_hold;
      next_rs_hold = rs_hold;
      next_disp_numeric = disp_numeric;
      next_disp_line = disp_line;
      next_disp_col = disp_col;
      // hardware sets win over a clear in the same cycle
      next_event_log = event_log;
      wr_val = '0;
      new_bu = bu_hold;
      new_rs = rs_hold;
      new_col = disp_col;
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `RFC_RESP_OKAY;
         case (aw_addr)
            `RFC_OFF_CTRL: begin
               next_ctrl = (ctrl & ~bmask) | (w_data & bmask);
            end
            `RFC_OFF_HOLD: begin
               wr_val = ({25'h0, bu_hold} << `RFC_HOLD_BU_LSB) |
                  ({25'h0, rs_hold} << `RFC_HOLD_RS_LSB);
               wr_val = (wr_val & ~bmask) | (w_data & bmask);
               new_bu = wr_val[`RFC_HOLD_BU_LSB +: 7];
               new_rs = wr_val[`RFC_HOLD_RS_LSB +: 7];
               // out of range values are dropped, old setting kept
               if (new_bu >= `RFC_HOLD_MIN && new_bu <= `RFC_HOLD_MAX) begin
                  next_bu_hold = new_bu;
               end
               if (new_rs >= `RFC_HOLD_MIN && new_rs <= `RFC_HOLD_MAX) begin
                  next_rs_hold = new_rs;
               end
            end
            `RFC_OFF_STAT: begin
            end
            `RFC_OFF_EVENT: begin
               if (w_strb[0]) begin
                  next_event_log = event_log & ~w_data[UNITS-1:0];
               end
            end
            `RFC_OFF_DISP: begin
               if (w_strb[0]) begin
                  next_disp_numeric = w_data[`RFC_DISP_NUMERIC];
                  next_disp_line = w_data[`RFC_DISP_LINE];
                  new_col = w_data[`RFC_DISP_COL_LSB +: 5];
                  if (new_col < 5'(`RFC_DISP_COLS)) begin
                     next_disp_col = new_col;
                  end
               end
            end
            default: begin
               next_bresp = `RFC_RESP_SLVERR;
            end
         endcase
      end
      next_event_log = next_event_log | fault_seen;
      next_awready = !next_aw_held;
      next_wready = !next_w_held;
      next_arready = s_axi_arready;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rresp = `RFC_RESP_OKAY;
         case (s_axi_araddr)
            `RFC_OFF_CTRL: next_rdata = ctrl;
            `RFC_OFF_HOLD: next_rdata = ({25'h0, bu_hold} <<
               `RFC_HOLD_BU_LSB) | ({25'h0, rs_hold} << `RFC_HOLD_RS_LSB);
            `RFC_OFF_STAT: next_rdata = stat_word;
            `RFC_OFF_EVENT: next_rdata = 32'(event_log);
            `RFC_OFF_DISP: next_rdata = {25'h0, disp_col, disp_line,
               disp_numeric};
            default: begin
               next_rdata = '0;
               next_rresp = `RFC_RESP_SLVERR;
            end
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl <= `RFC_CTRL_RST;
         bu_hold <= `RFC_BU_HOLD_RST;
         rs_hold <= `RFC_RS_HOLD_RST;
         event_log <= NO_UNITS;
         disp_numeric <= 1'b0;
         disp_line <= 1'b0;
         disp_col <= '0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RFC_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `RFC_RESP_OKAY;
      end else begin
         ctrl <= next_ctrl;
         bu_hold <= next_bu_hold;
         rs_hold <= next_rs_hold;
         event_log <= next_event_log;
         disp_numeric <= next_disp_numeric;
         disp_line <= next_disp_line;
         disp_col <= next_disp_col;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end
endmodule : rfc_failover_ctrl

// ---- testbench/rfc_failover_ctrl_monitor.sv ----
module rfc_failover_ctrl_monitor #(
   parameter int UNITS = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // watched ports
   input wire logic if_switch_sense,
   input wire logic key_press,
   input wire logic [UNITS-1:0] traffic_unit_interface_online,
   input wire logic [UNITS-1:0] traffic_unit_interface_bridged,
   input wire logic [UNITS-1:0] traffic_tx_if_enable,
   input wire logic spare_unit_interface_online,
   input wire logic spare_tx_if_enable,
   input wire logic [4:0] cursor_col,
   input wire logic saver_active,
   input wire logic [4:0] saver_scroll
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_bridge_onehot: assert property (
      $onehot0(traffic_unit_interface_bridged)) else $error("two bridged");
   chk_spare_owner: assert property (
      spare_unit_interface_online |-> |traffic_unit_interface_bridged)
      else $error("spare online with no unit");
   chk_bridge_first: assert property (
      $rose(spare_unit_interface_online)
      |-> $past(traffic_unit_interface_bridged != 0))
      else $error("backup without bridge");
   chk_backup_offline: assert property (
      spare_unit_interface_online |->
      (traffic_unit_interface_online & traffic_unit_interface_bridged) == 0)
      else $error("backed-up unit still online");
   chk_spare_tx: assert property (
      spare_tx_if_enable == spare_unit_interface_online)
      else $error("spare tx mismatch");
   // sense may pass a synchroniser, so give it three quiet cycles
   chk_tx_shut: assert property (
      !if_switch_sense [*3] |->
      traffic_tx_if_enable == traffic_unit_interface_online)
      else $error("offline tx not shut");
   chk_tx_kept: assert property (
      if_switch_sense [*3] |-> (traffic_tx_if_enable
      & traffic_unit_interface_bridged) == traffic_unit_interface_bridged)
      else $error("offline tx dropped");
   chk_saver_key: assert property (
      key_press |=> !saver_active) else $error("saver kept");
   chk_scroll_range: assert property (
      saver_scroll <= 5'h17) else $error("scroll out of line");
   chk_cursor_col: assert property (
      cursor_col <= 5'h17) else $error("cursor out of line");
   cover property ($rose(spare_unit_interface_online));
   cover property ($fell(spare_unit_interface_online));
   cover property ($rose(saver_active));
endmodule : rfc_failover_ctrl_monitor

// ---- testbench/rfc_unit_model.sv ----
module rfc_unit_model (
   // clock
   input wire logic clk,
   // bench faults to inject
   input wire logic [7:0] mod_brk,
   input wire logic [7:0] demod_brk,
   input wire logic [1:0] spare_brk,
   input wire logic fitted,
   // controller side
   input wire logic spare_on,
   input wire logic [7:0] bridged,
   output logic [7:0] tmf,
   output logic [7:0] tdf,
   output logic smf,
   output logic sdf,
   output logic sense,
   output logic [7:0] path
);
   timeunit 1ns;
   timeprecision 1ns;
   // units report faults as polled levels, so one cycle late
   always_ff @(posedge clk) begin
      tmf <= mod_brk;
      tdf <= demod_brk;
      {sdf, smf} <= spare_brk;
   end
   assign sense = fitted;
   assign path = (fitted && spare_on) ? bridged : 8'h00;
endmodule : rfc_unit_model

// ---- testbench/redundancy_failover_controller_test.sv ----
module redundancy_failover_controller_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic [7:0] awa, ara, tmf, tdf, mb, db, online, bridged, tx_en, path;
   logic [31:0] wd, rdat, rd;
   logic [3:0] ws;
   logic [1:0] bresp, rresp, rsp, sb;
   logic smf, sdf, sense, key_press, spare_on, spare_tx, fitted;
   logic led, c_on, c_ul, c_line, saver;
   logic [4:0] c_col, scroll;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   rfc_failover_ctrl #(.UNITS(8), .TICK_CYCLES(10), .SAVER_S(5)) dut_u (
      .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .traffic_mod_fault(tmf), .traffic_demod_fault(tdf),
      .spare_mod_fault(smf), .spare_demod_fault(sdf),
      .if_switch_sense(sense), .key_press(key_press),
      .traffic_unit_interface_online(online),
      .traffic_unit_interface_bridged(bridged),
      .traffic_tx_if_enable(tx_en), .spare_unit_interface_online(spare_on),
      .spare_tx_if_enable(spare_tx), .stored_event_led(led),
      .cursor_on(c_on), .cursor_underline(c_ul), .cursor_line(c_line),
      .cursor_col(c_col), .saver_active(saver), .saver_scroll(scroll));
   rfc_unit_model units_u (.clk(clk), .mod_brk(mb), .demod_brk(db),
      .spare_brk(sb), .fitted(fitted), .spare_on(spare_on),
      .bridged(bridged), .tmf(tmf), .tdf(tdf), .smf(smf), .sdf(sdf),
      .sense(sense), .path(path));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (bad_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (bv !== 1'b1);
      br <= 1'b0;
      rsp = bresp;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rr <= 1'b0;
      rd = rdat;
      rsp = rresp;
   endtask : axi_rd
   task automatic fault(input logic [7:0] m, input logic [7:0] d,
                        input logic [1:0] s);
      @(posedge clk);
      mb <= m;
      db <= d;
      sb <= s;
   endtask : fault
   // bounded wait; the compare at its end catches a miss
   task automatic wait_br(input logic [7:0] v);
      int i = 0;
      while (bridged !== v && i < 80) begin
         @(posedge clk);
         i++;
      end
      check(bridged, v);
      tick(2);
   endtask : wait_br
   task automatic t_reset();
      axi_rd(8'h00);
      check(rd, 32'h0);
      check(online, 8'h00);
      axi_rd(8'h04);
      check(rd, 32'h0505);
      axi_rd(8'h14);
      check(rsp, 2'h2);
   endtask : t_reset
   task automatic t_hold();
      axi_wr(8'h04, 32'h6401);
      axi_rd(8'h04);
      check(rd, 32'h0505);
      axi_wr(8'h04, 32'h6363);
      axi_rd(8'h04);
      check(rd, 32'h6363);
      axi_wr(8'h04, 32'h0202);
   endtask : t_hold
   task automatic t_display();
      axi_wr(8'h10, 32'h5f);
      tick(2);
      check({c_ul, c_line, c_col}, 7'h77);
      axi_wr(8'h10, 32'h60);
      tick(2);
      check(c_col, 5'h17);
   endtask : t_display
   task automatic t_manual();
      logic l;
      axi_wr(8'h00, 32'h0300);
      fault(8'h01, 8'h00, 2'h0);
      tick(50);
      check({spare_on, bridged}, 9'h000);
      l = led;
      tick(10);
      check({c_on, led}, {~l, ~l});
      fault(8'h00, 8'h00, 2'h0);
   endtask : t_manual
   task automatic t_backup();
      fault(8'h03, 8'h00, 2'h1);
      axi_wr(8'h00, 32'h0301);
      tick(50);
      check(spare_on, 1'b0);
      fault(8'h03, 8'h00, 2'h0);
      tick(19);
      check({spare_on, bridged}, 9'h000);
      wait_br(8'h01);
      check({spare_on, online}, 9'h102);
      fault(8'h00, 8'h00, 2'h0);
      tick(50);
      check({spare_on, bridged}, 9'h101);
      fault(8'h02, 8'h00, 2'h0);
      wait_br(8'h02);
      check({spare_on, online}, 9'h101);
      axi_wr(8'h00, 32'h0303);
      fault(8'h00, 8'h00, 2'h0);
      wait_br(8'h00);
      check({spare_on, online}, 9'h003);
   endtask : t_backup
   task automatic t_mask();
      @(posedge clk);
      fitted <= 1'b1;
      axi_wr(8'h0c, 32'hff);
      axi_wr(8'h00, 32'h0305);
      fault(8'h03, 8'h00, 2'h0);
      tick(50);
      check(spare_on, 1'b0);
      axi_rd(8'h0c);
      check(rd, 32'h0);
      axi_rd(8'h08);
      check(rd[0], 1'b1);
      fault(8'h03, 8'h01, 2'h0);
      wait_br(8'h01);
      check(path, 8'h01);
      check(tx_en, 8'h03);
      axi_rd(8'h0c);
      check(rd, 32'h01);
      check(led, 1'b1);
   endtask : t_mask
   task automatic t_saver();
      @(posedge clk);
      key_press <= 1'b1;
      @(posedge clk);
      key_press <= 1'b0;
      tick(30);
      check(saver, 1'b0);
      tick(40);
      check(saver, 1'b1);
      tick(20);
      check(scroll == 5'h00, 1'b0);
      @(posedge clk);
      key_press <= 1'b1;
      @(posedge clk);
      key_press <= 1'b0;
      tick(1);
      check({saver, scroll}, 6'h00);
   endtask : t_saver
   initial begin
      rst_n = 1'b0;
      {awv, wv, br, arv, rr, key_press, fitted} = 7'h00;
      {awa, ara, mb, db, sb, wd} = 66'h0;
      ws = 4'hf;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_hold();
      t_display();
      t_manual();
      t_backup();
      t_mask();
      t_saver();
      complete_run();
   end
endmodule : redundancy_failover_controller_test
bind rfc_failover_ctrl rfc_failover_ctrl_monitor #(.UNITS(UNITS)) mon_u (
   .clk(clk), .rst_n(rst_n), .if_switch_sense(if_switch_sense),
   .key_press(key_press),
   .traffic_unit_interface_online(traffic_unit_interface_online),
   .traffic_unit_interface_bridged(traffic_unit_interface_bridged),
   .traffic_tx_if_enable(traffic_tx_if_enable),
   .spare_unit_interface_online(spare_unit_interface_online),
   .spare_tx_if_enable(spare_tx_if_enable), .cursor_col(cursor_col),
   .saver_active(saver_active), .saver_scroll(saver_scroll));
